// ---- acs_map.svh ----
// field positions, reset values and timing counts of the conversion sequencer
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// control one fields
`define ACS_C1_IRQ_EN_BIT 6
`define ACS_C1_CONT_BIT 5
`define ACS_C1_CHAN_MSB 4
`define ACS_C1_CHAN_LSB 0
// control two fields
`define ACS_C2_HWTRIG_BIT 6
`define ACS_C2_CMP_EN_BIT 5
`define ACS_C2_CMP_GT_BIT 4
// config fields
`define ACS_CFG_LP_BIT 7
`define ACS_CFG_DIV_MSB 6
`define ACS_CFG_DIV_LSB 5
`define ACS_CFG_LSMP_BIT 4
`define ACS_CFG_MODE_MSB 3
`define ACS_CFG_MODE_LSB 2
`define ACS_CFG_SRC_MSB 1
`define ACS_CFG_SRC_LSB 0

// reset values and the channel-off code
`define ACS_CHAN_RESET 5'h1F
`define ACS_CHAN_OFF 5'h1F
`define ACS_BYTE_RESET 8'h00
`define ACS_CV_RESET 12'h000

// timing
`define ACS_REF_CLK_NS 100
`define ACS_ASYNC_STARTUP_NS 5000
`define ACS_ASYNC_STARTUP_CYC (`ACS_ASYNC_STARTUP_NS / `ACS_REF_CLK_NS)
`define ACS_SAMPLE_SHORT_TICKS 5'h04
`define ACS_SAMPLE_LONG_TICKS 5'h18
`define ACS_ASYNC_DIV 8'h04
`define ACS_TOP_BIT_WIDE 4'hB
`define ACS_TOP_BIT_NARROW 4'h8

`endif

// ---- acs_pkg.sv ----
// types shared by the conversion sequencer modules
package acs_pkg;

    typedef enum logic [3:0] {
        ACS_IDLE    = 4'b0001,
        ACS_WARMUP  = 4'b0010,
        ACS_SAMPLE  = 4'b0100,
        ACS_CONVERT = 4'b1000
    } acs_state_t;

    typedef enum logic [1:0] {
        ACS_MODE_8  = 2'b00,
        ACS_MODE_12 = 2'b01,
        ACS_MODE_10 = 2'b10,
        ACS_MODE_RSV = 2'b11
    } acs_mode_t;

    typedef enum logic [1:0] {
        ACS_SRC_BUS   = 2'b00,
        ACS_SRC_BUS2  = 2'b01,
        ACS_SRC_ALT   = 2'b10,
        ACS_SRC_ASYNC = 2'b11
    } acs_src_t;

endpackage

// ---- acs_clk_if.sv ----
// sequencer to clock generator link
`timescale 1ns/1ps
interface acs_clk_if;
    import acs_pkg::*;
    logic run;
    acs_src_t source_sel;
    logic [1:0] divide_sel;
    logic alt_edge;
    logic tick;
    logic async_on;

    modport gen (input run, input source_sel, input divide_sel, input alt_edge, output tick, output async_on);
    modport seq (output run, output source_sel, output divide_sel, output alt_edge, input tick, input async_on);
endinterface

// ---- acs_clock_gen.sv ----
// converter clock tick generator
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_clock_gen
    import acs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // link to sequencer
    acs_clk_if.gen cif
);
    logic [7:0] async_cnt_reg;
    logic half_reg;
    logic [2:0] div_cnt_reg;
    logic tick_reg;
    logic async_on_reg;
    logic src_pulse;

    wire async_wrap = (async_cnt_reg == (`ACS_ASYNC_DIV - 8'h01));
    wire [2:0] div_mask = 3'((4'h1 << cif.divide_sel) - 4'h1);
    wire async_want = cif.run && (cif.source_sel == ACS_SRC_ASYNC);

    always_comb begin
        unique case (cif.source_sel)
            ACS_SRC_BUS: src_pulse = 1'b1;
            ACS_SRC_BUS2: src_pulse = half_reg;
            ACS_SRC_ALT: src_pulse = cif.alt_edge;
            ACS_SRC_ASYNC: src_pulse = async_wrap && async_on_reg; // see R26
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            async_cnt_reg <= 8'h00;
            half_reg <= 1'b0;
            async_on_reg <= 1'b0;
        end else if (ce) begin
            async_on_reg <= async_want; // see R12
            half_reg <= cif.run ? ~half_reg : 1'b0;
            async_cnt_reg <= (async_on_reg && !async_wrap) ? async_cnt_reg + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= 3'h0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            if (!cif.run) begin
                div_cnt_reg <= 3'h0;
                tick_reg <= 1'b0;
            end else if (src_pulse) begin
                div_cnt_reg <= (div_cnt_reg == div_mask) ? 3'h0 : div_cnt_reg + 3'h1;
                tick_reg <= (div_cnt_reg == div_mask);
            end else begin
                tick_reg <= 1'b0;
            end
        end
    end

    assign cif.tick = tick_reg;
    assign cif.async_on = async_on_reg;
endmodule

// ---- acs_sequencer.sv ----
// conversion sequencer of a successive-approximation converter
`timescale 1ns/1ps
`include "acs_map.svh"
// Function
// R1 - sw trigger: control one write starts unless channel all ones
// R2 - hw trigger selected: each trigger starts
// R3 - continuous restarts after each transfer
// R4 - transfer sets flag, irq if enabled
// R5 - 12/10-bit: pending high read blocks transfer
// R6 - blocked restarts, except single compare-false
// R7 - no result reads during single conversion
// R8 - control one write aborts, restarts unless channel all ones
// R9 - control two, config, compare writes abort
// R10 - reset, or stop without async clock, aborts
// R11 - abort keeps result; reset clears it
// R12 - idle until started; async clock only then
// R13 - sample 3.5 or 23.5 clocks, then approximate
// R14 - first conversion at most 20/23/40/43 clocks plus bus
// R15 - later continuous at most 17/20/37/40 clocks
// R16 - continuous sample timing needs fast bus clock
// R17 - compare adds negated value; selector picks >= or <
// R18 - compare true stores the difference
// R19 - compare false: flag clear, no transfer
// R20 - wait: conversion completes; trigger or continuous starts
// R21 - wait completion sets flag, wakes by irq
// R22 - bus, half bus, async clock usable in wait
// R23 - converter off in reset and channel all ones
// R24 - hw trigger on rising edge; ignored while busy
// R25 - round to 10 bits, or 8 bits low byte only
// R26 - fourth clock choice is the async clock
module acs_sequencer
    import acs_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // control writes, shared data byte
    input wire logic [7:0] ctl_wdata,
    input wire logic conv_control_one_wr,
    input wire logic conv_control_two_wr,
    input wire logic conv_config_wr,
    input wire logic compare_value_high_wr,
    input wire logic compare_value_low_wr,
    // result reads
    input wire logic result_high_rd,
    input wire logic result_low_rd,
    // chip mode and pins
    input wire logic stop_mode,
    input wire logic hw_trigger_input,
    input wire logic alternate_clock,
    // analog side
    input wire logic comp_above,
    output logic sample_enable,
    output logic [11:0] dac_code,
    output logic converter_enable,
    output logic low_power_bias,
    output logic internal_async_clock_enable,
    // status
    output logic [7:0] result_high,
    output logic [7:0] result_low,
    output logic complete_flag,
    output logic conv_active,
    output logic conv_irq
);
    acs_clk_if cif ();

    // control state
    logic [4:0] channel_select_reg;
    logic complete_irq_enable_reg;
    logic continuous_enable_reg;
    logic hw_trigger_select_reg;
    logic compare_enable_reg;
    logic compare_greater_select_reg;
    logic low_power_select_reg;
    logic [1:0] clock_divide_select_reg;
    logic long_sample_select_reg;
    acs_mode_t mode_reg;
    acs_src_t clock_source_select_reg;
    logic [11:0] compare_value_reg;

    // sequencing state
    acs_state_t state_reg;
    acs_state_t state_next;
    logic [5:0] warm_cnt_reg;
    logic [4:0] sample_cnt_reg;
    logic [3:0] bit_idx_reg;
    logic [11:0] dac_code_reg;
    logic high_pending_reg;
    logic [7:0] result_high_reg;
    logic [7:0] result_low_reg;
    logic complete_flag_reg;
    logic irq_reg;
    logic sample_en_reg;
    logic conv_enable_reg;
    logic lp_bias_reg;
    logic active_reg;

    // pin synchronisers: hw trigger and alternate clock
    logic [1:0] pin_in;
    logic [1:0] pin_s1_reg;
    logic [1:0] pin_s2_reg;
    logic [1:0] pin_s3_reg;
    logic [1:0] pin_filt_reg;
    logic [1:0] pin_prev_reg;
    logic [1:0] pin_rise;

    assign pin_in = {alternate_clock, hw_trigger_input};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    pin_s1_reg[gi] <= 1'b0;
                    pin_s2_reg[gi] <= 1'b0;
                    pin_s3_reg[gi] <= 1'b0;
                    pin_filt_reg[gi] <= 1'b0;
                    pin_prev_reg[gi] <= 1'b0;
                end else if (ce) begin
                    pin_s1_reg[gi] <= pin_in[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                    pin_s3_reg[gi] <= pin_s2_reg[gi];
                    if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
                        pin_filt_reg[gi] <= pin_s3_reg[gi];
                    end
                    pin_prev_reg[gi] <= pin_filt_reg[gi];
                end
            end
            assign pin_rise[gi] = pin_filt_reg[gi] && !pin_prev_reg[gi];
        end
    endgenerate

    // decode of the writes
    wire [4:0] wr_channel = ctl_wdata[`ACS_C1_CHAN_MSB:`ACS_C1_CHAN_LSB];
    wire wr_channel_valid = (wr_channel != `ACS_CHAN_OFF);
    wire cv_wr = compare_value_high_wr || compare_value_low_wr;
    wire mode_wr = conv_control_two_wr || conv_config_wr || cv_wr;
    wire async_sel = (clock_source_select_reg == ACS_SRC_ASYNC);
    wire stop_abort = stop_mode && !async_sel;
    wire chan_off = (channel_select_reg == `ACS_CHAN_OFF);
    wire idle = (state_reg == ACS_IDLE);
    wire narrow = (mode_reg == ACS_MODE_8);

    // starts
    wire sw_start = conv_control_one_wr && !hw_trigger_select_reg && wr_channel_valid; // see R1 see R8
    wire hw_start = hw_trigger_select_reg && pin_rise[0] && idle && !chan_off && !stop_abort; // see R2 see R24
    wire abort_any = conv_control_one_wr || mode_wr || stop_abort; // see R9 see R10
    wire start_any = sw_start || (hw_start && !abort_any);
    acs_state_t first_state;
    assign first_state = async_sel ? ACS_WARMUP : ACS_SAMPLE; // see R14

    // sample length and approximation width
    wire [4:0] sample_len = long_sample_select_reg ? `ACS_SAMPLE_LONG_TICKS : `ACS_SAMPLE_SHORT_TICKS; // see R13
    wire [3:0] top_bit = narrow ? `ACS_TOP_BIT_NARROW : `ACS_TOP_BIT_WIDE;
    wire [5:0] warm_len = 6'(`ACS_ASYNC_STARTUP_CYC);
    wire tick = cif.tick;
    wire sample_done = (state_reg == ACS_SAMPLE) && tick && (sample_cnt_reg == sample_len - 5'h01);
    wire conv_done = (state_reg == ACS_CONVERT) && tick && (bit_idx_reg == 4'h0);

    // final code with the last decision folded in
    wire [11:0] final_code = {dac_code_reg[11:1], dac_code_reg[0] && comp_above};
    wire [12:0] round10_sum = {1'b0, final_code} + 13'h0002;
    wire [9:0] round10 = round10_sum[12] ? 10'h3FF : round10_sum[11:2];
    wire [9:0] round8_sum = {1'b0, final_code[8:0]} + 10'h001;
    wire [7:0] round8 = round8_sum[9] ? 8'hFF : round8_sum[8:1];

    logic [11:0] conv_value;
    always_comb begin
        unique case (mode_reg)
            ACS_MODE_8: conv_value = {4'h0, round8}; // see R25
            ACS_MODE_10: conv_value = {2'h0, round10}; // see R25
            default: conv_value = final_code;
        endcase
    end

    // compare: result plus two's complement of compare value
    wire [12:0] cmp_sum = {1'b0, conv_value} + {1'b1, ~compare_value_reg} + 13'h0001; // see R17
    wire cmp_ge = !cmp_sum[12];
    wire cmp_true = compare_greater_select_reg ? cmp_ge : !cmp_ge; // see R17
    wire cmp_fail = compare_enable_reg && !cmp_true;
    wire [11:0] xfer_value = compare_enable_reg ? cmp_sum[11:0] : conv_value; // see R18
    wire blocked = !narrow && high_pending_reg; // see R5
    wire do_xfer = conv_done && !cmp_fail && !blocked; // see R4 see R19
    wire again = conv_done && (cmp_fail ? continuous_enable_reg : (blocked || continuous_enable_reg)); // see R3 see R6

    // next state
    always_comb begin
        state_next = state_reg;
        if (stop_abort) begin
            state_next = ACS_IDLE; // see R10
        end else if (start_any) begin
            state_next = first_state;
        end else if (abort_any) begin
            state_next = ACS_IDLE; // see R8 see R9
        end else begin
            unique case (state_reg)
                ACS_IDLE: state_next = ACS_IDLE; // see R12
                ACS_WARMUP: begin
                    if (warm_cnt_reg == warm_len - 6'h01) begin
                        state_next = ACS_SAMPLE;
                    end
                end
                ACS_SAMPLE: begin
                    if (sample_done) begin
                        state_next = ACS_CONVERT;
                    end
                end
                ACS_CONVERT: begin
                    if (conv_done) begin
                        state_next = again ? ACS_SAMPLE : ACS_IDLE; // see R15 see R16 see R20
                    end
                end
                default: state_next = ACS_IDLE;
            endcase
        end
    end

    // control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            channel_select_reg <= `ACS_CHAN_RESET;
            complete_irq_enable_reg <= 1'b0;
            continuous_enable_reg <= 1'b0;
        end else if (ce && conv_control_one_wr) begin
            channel_select_reg <= wr_channel;
            complete_irq_enable_reg <= ctl_wdata[`ACS_C1_IRQ_EN_BIT];
            continuous_enable_reg <= ctl_wdata[`ACS_C1_CONT_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hw_trigger_select_reg <= 1'b0;
            compare_enable_reg <= 1'b0;
            compare_greater_select_reg <= 1'b0;
        end else if (ce && conv_control_two_wr) begin
            hw_trigger_select_reg <= ctl_wdata[`ACS_C2_HWTRIG_BIT];
            compare_enable_reg <= ctl_wdata[`ACS_C2_CMP_EN_BIT];
            compare_greater_select_reg <= ctl_wdata[`ACS_C2_CMP_GT_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_power_select_reg <= 1'b0;
            clock_divide_select_reg <= 2'h0;
            long_sample_select_reg <= 1'b0;
            mode_reg <= ACS_MODE_8;
            clock_source_select_reg <= ACS_SRC_BUS;
        end else if (ce && conv_config_wr) begin
            low_power_select_reg <= ctl_wdata[`ACS_CFG_LP_BIT];
            clock_divide_select_reg <= ctl_wdata[`ACS_CFG_DIV_MSB:`ACS_CFG_DIV_LSB];
            long_sample_select_reg <= ctl_wdata[`ACS_CFG_LSMP_BIT];
            mode_reg <= acs_mode_t'(ctl_wdata[`ACS_CFG_MODE_MSB:`ACS_CFG_MODE_LSB]);
            clock_source_select_reg <= acs_src_t'(ctl_wdata[`ACS_CFG_SRC_MSB:`ACS_CFG_SRC_LSB]);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            compare_value_reg <= `ACS_CV_RESET;
        end else if (ce) begin
            if (compare_value_high_wr) begin
                compare_value_reg[11:8] <= ctl_wdata[3:0];
            end
            if (compare_value_low_wr) begin
                compare_value_reg[7:0] <= ctl_wdata;
            end
        end
    end

    // sequencing counters and approximation register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ACS_IDLE;
            warm_cnt_reg <= 6'h00;
            sample_cnt_reg <= 5'h00;
        end else if (ce) begin
            state_reg <= state_next;
            warm_cnt_reg <= (state_next == ACS_WARMUP && state_reg == ACS_WARMUP) ? warm_cnt_reg + 6'h01 : 6'h00;
            if (state_next != ACS_SAMPLE || state_reg != ACS_SAMPLE) begin
                sample_cnt_reg <= 5'h00;
            end else if (tick) begin
                sample_cnt_reg <= sample_cnt_reg + 5'h01; // see R13
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_idx_reg <= 4'h0;
            dac_code_reg <= 12'h000;
        end else if (ce) begin
            if (state_next == ACS_CONVERT && state_reg != ACS_CONVERT) begin
                bit_idx_reg <= top_bit;
                dac_code_reg <= 12'(12'h001 << top_bit);
            end else if (state_reg == ACS_CONVERT && tick && bit_idx_reg != 4'h0) begin
                bit_idx_reg <= bit_idx_reg - 4'h1;
                dac_code_reg <= (comp_above ? dac_code_reg : (dac_code_reg & ~(12'(12'h001 << bit_idx_reg))))
                    | 12'(12'h001 << (bit_idx_reg - 4'h1));
            end
        end
    end

    // results, blocking and completion flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_high_reg <= `ACS_BYTE_RESET; // see R11
            result_low_reg <= `ACS_BYTE_RESET;
        end else if (ce && do_xfer) begin
            result_low_reg <= xfer_value[7:0];
            if (!narrow) begin
                result_high_reg <= {4'h0, xfer_value[11:8]}; // see R25
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            high_pending_reg <= 1'b0;
            complete_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            if (result_low_rd) begin
                high_pending_reg <= 1'b0;
            end else if (result_high_rd && !narrow) begin
                high_pending_reg <= 1'b1; // see R5 see R7
            end
            if (do_xfer) begin
                complete_flag_reg <= 1'b1; // see R4
            end else if (conv_control_one_wr || result_low_rd) begin
                complete_flag_reg <= 1'b0;
            end
            irq_reg <= (do_xfer || (complete_flag_reg && !conv_control_one_wr && !result_low_rd))
                && complete_irq_enable_reg; // see R21
        end
    end

    // analog side controls
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_en_reg <= 1'b0;
            conv_enable_reg <= 1'b0;
            lp_bias_reg <= 1'b0;
            active_reg <= 1'b0;
        end else if (ce) begin
            active_reg <= (state_next != ACS_IDLE);
            sample_en_reg <= (state_next == ACS_SAMPLE); // see R13
            conv_enable_reg <= (state_next != ACS_IDLE) && !chan_off; // see R23
            lp_bias_reg <= low_power_select_reg && (state_next != ACS_IDLE);
        end
    end

    // clock generator link: running whenever the sequencer is not idle (warmup, sample, convert)
    assign cif.run = !idle; // see R12 see R22
    assign cif.source_sel = clock_source_select_reg;
    assign cif.divide_sel = clock_divide_select_reg;
    assign cif.alt_edge = pin_rise[1];

    acs_clock_gen u_clock_gen (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .cif(cif)
    );

    assign sample_enable = sample_en_reg;
    assign dac_code = dac_code_reg;
    assign converter_enable = conv_enable_reg;
    assign low_power_bias = lp_bias_reg;
    assign internal_async_clock_enable = cif.async_on; // see R26
    assign result_high = result_high_reg;
    assign result_low = result_low_reg;
    assign complete_flag = complete_flag_reg;
    assign conv_active = active_reg;
    assign conv_irq = irq_reg;
endmodule

// ---- acs_sequencer_properties.sv ----
// port-level assertion checker for the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // control writes, reads and chip mode
    input wire logic [7:0] ctl_wdata,
    input wire logic conv_control_one_wr,
    input wire logic conv_control_two_wr,
    input wire logic conv_config_wr,
    input wire logic compare_value_high_wr,
    input wire logic compare_value_low_wr,
    input wire logic result_high_rd,
    input wire logic stop_mode,
    // observed outputs
    input wire logic sample_enable,
    input wire logic converter_enable,
    input wire logic [7:0] result_high,
    input wire logic [7:0] result_low,
    input wire logic complete_flag,
    input wire logic conv_active,
    input wire logic conv_irq
);
    logic hw_mode_reg;
    logic async_src_reg;
    wire mode_write = ce && (conv_control_two_wr || conv_config_wr || compare_value_high_wr || compare_value_low_wr);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hw_mode_reg <= 1'b0;
            async_src_reg <= 1'b0;
        end else if (ce) begin
            if (conv_control_two_wr) hw_mode_reg <= ctl_wdata[6];
            if (conv_config_wr) async_src_reg <= (ctl_wdata[1:0] == 2'h3);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_sw_start: assert property (ce && conv_control_one_wr && !hw_mode_reg && !stop_mode
        && ctl_wdata[4:0] != 5'h1F |=> conv_active) else $error("soft start missed");
    a_chan_off: assert property (ce && conv_control_one_wr && ctl_wdata[4:0] == 5'h1F |=> !conv_active)
        else $error("chan off active");
    a_mode_abort: assert property (mode_write && !conv_control_one_wr |=> !conv_active)
        else $error("no mode abort");
    a_stop_abort: assert property (ce && stop_mode && !async_src_reg |=> !conv_active)
        else $error("no stop abort");
    a_result_hold: assert property ($changed({result_high, result_low}) |-> complete_flag)
        else $error("result moved without flag");
    a_flag_cause: assert property ($rose(complete_flag) |-> $past(conv_active))
        else $error("flag without conversion");
    a_irq_flag: assert property (conv_irq |-> complete_flag) else $error("interrupt without flag");
    a_idle_quiet: assert property (!$past(conv_active) && !conv_active |-> !sample_enable && !converter_enable)
        else $error("analog on in idle");
    a_sample_len: assert property ($fell(sample_enable) && conv_active |-> $past(sample_enable, 4))
        else $error("sample short");
    c_done: cover property ($rose(complete_flag));
    c_block: cover property (result_high_rd ##1 conv_active);
    c_stop: cover property (stop_mode ##1 $fell(conv_active));
endmodule
bind acs_sequencer acs_sequencer_checker u_checker (.ref_clk, .rst, .ce, .ctl_wdata, .conv_control_one_wr,
    .conv_control_two_wr, .conv_config_wr, .compare_value_high_wr, .compare_value_low_wr, .result_high_rd,
    .stop_mode, .sample_enable, .converter_enable, .result_high, .result_low, .complete_flag, .conv_active,
    .conv_irq);

// ---- acs_analog_model.sv ----
// analog channel comparator and hardware trigger source model
`timescale 1ns/1ps
module acs_analog_model (
    // clock
    input wire logic ref_clk,
    // analog side
    input wire logic [11:0] level,
    input wire logic [11:0] dac_code,
    output logic comp_above,
    // trigger source
    input wire logic trig_req,
    output logic hw_trigger_input
);
    int hold_cnt = 0;
    assign comp_above = (level >= dac_code);
    // trigger held for several cycles so the input filter sees a clean edge
    always @(posedge ref_clk) begin
        if (trig_req) hold_cnt <= 8;
        else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
    end
    assign hw_trigger_input = (hold_cnt > 0);
endmodule

// ---- adc_conversion_sequencer_bench.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic [4:0] wr_s = 5'h00;
    logic rd_h = 1'b0;
    logic rd_l = 1'b0;
    logic stop_mode = 1'b0;
    logic trig_req = 1'b0;
    logic [11:0] level = 12'hA5C;
    logic hw_trig, comp_above, sample_enable, converter_enable, low_power_bias, async_en;
    logic complete_flag, conv_active, conv_irq;
    logic [11:0] dac_code;
    logic [7:0] result_high, result_low;
    int bad_count = 0;
    int n_checks = 0;
    int cyc;
    always #50 ref_clk = ~ref_clk;
    // strobes: c1, c2, cfg, cv high, cv low
    acs_sequencer DUT (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .ctl_wdata(wdata),
        .conv_control_one_wr(wr_s[0]), .conv_control_two_wr(wr_s[1]), .conv_config_wr(wr_s[2]),
        .compare_value_high_wr(wr_s[3]), .compare_value_low_wr(wr_s[4]), .result_high_rd(rd_h),
        .result_low_rd(rd_l), .stop_mode(stop_mode), .hw_trigger_input(hw_trig), .alternate_clock(1'b0),
        .comp_above(comp_above), .sample_enable(sample_enable), .dac_code(dac_code),
        .converter_enable(converter_enable), .low_power_bias(low_power_bias),
        .internal_async_clock_enable(async_en), .result_high(result_high), .result_low(result_low),
        .complete_flag(complete_flag), .conv_active(conv_active), .conv_irq(conv_irq));
    acs_analog_model PARTNER (.ref_clk(ref_clk), .level(level), .dac_code(dac_code), .comp_above(comp_above),
        .trig_req(trig_req), .hw_trigger_input(hw_trig));
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge ref_clk);
        wr_s[k] <= 1'b1;
        wdata <= d;
        @(posedge ref_clk);
        wr_s <= 5'h00;
    endtask
    task automatic rd(input logic high);
        @(posedge ref_clk);
        rd_h <= high;
        rd_l <= !high;
        @(posedge ref_clk);
        rd_h <= 1'b0;
        rd_l <= 1'b0;
    endtask
    task automatic wait_flag(input int lim);
        cyc = 0;
        do begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end while (complete_flag !== 1'b1 && cyc < lim);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        wr(2, 8'h04);
        wr(1, 8'h00);
        wr(0, 8'h41);
        wait_flag(40);
        chk(cyc <= 28, "single slow");
        chk(result_high === 8'h0A && result_low === 8'h5C, "single result");
        chk(conv_irq === 1'b1, "irq");
        rd(1);
        rd(0);
        $display("test single done");
        @(posedge ref_clk) level <= 12'h3C1;
        wr(0, 8'h01);
        idle(4);
        chk(conv_active === 1'b1, "soft start");
        wr(2, 8'h04);
        idle(1);
        chk(conv_active === 1'b0, "cfg abort");
        idle(30);
        chk(complete_flag === 1'b0 && result_low === 8'h5C, "abort keeps");
        wr(0, 8'h01);
        idle(3);
        wr(0, 8'h1F);
        idle(1);
        chk(conv_active === 1'b0, "chan off");
        $display("test abort done");
        wr(3, 8'h08);
        wr(4, 8'h00);
        wr(1, 8'h20);
        wr(0, 8'h01);
        wait_flag(40);
        chk(result_high === 8'h0B && result_low === 8'hC1, "lt diff");
        rd(1);
        rd(0);
        wr(1, 8'h30);
        wr(0, 8'h01);
        idle(40);
        chk(complete_flag === 1'b0 && conv_active === 1'b0, "cmp false stops");
        chk(result_high === 8'h0B && result_low === 8'hC1, "cmp false keeps");
        $display("test compare done");
        @(posedge ref_clk) level <= 12'h2E7;
        wr(1, 8'h00);
        wr(0, 8'h01);
        idle(3);
        rd(1);
        idle(30);
        chk(complete_flag === 1'b0 && conv_active === 1'b1, "block restarts");
        chk(result_low === 8'hC1, "block lost");
        rd(0);
        wait_flag(40);
        chk(result_high === 8'h02 && result_low === 8'hE7, "unblocked");
        rd(1);
        rd(0);
        $display("test blocking done");
        wr(1, 8'h40);
        wr(0, 8'h21);
        idle(3);
        chk(conv_active === 1'b0, "hw no sw start");
        @(posedge ref_clk) trig_req <= 1'b1;
        @(posedge ref_clk) trig_req <= 1'b0;
        wait_flag(50);
        chk(complete_flag === 1'b1, "hw conv");
        rd(1);
        rd(0);
        idle(1);
        wait_flag(17);
        chk(complete_flag === 1'b1, "cont restart");
        @(posedge ref_clk) stop_mode <= 1'b1;
        idle(2);
        chk(conv_active === 1'b0, "stop aborts");
        @(posedge ref_clk) stop_mode <= 1'b0;
        $display("test continuous done");
        wr(1, 8'h00);
        wr(0, 8'h01);
        idle(5);
        @(posedge ref_clk) rst <= 1'b1;
        idle(2);
        chk(result_high === 8'h00 && result_low === 8'h00 && conv_active === 1'b0, "reset clears");
        @(posedge ref_clk) rst <= 1'b0;
        $display("test reset done");
        conclude();
    end
endmodule
